// *** rtl/two_level_vectored_irq.sv ***
// Two level vectored interrupt controller with seven sources.
// Assumes the core acknowledges a long call and pulses a return strobe.
`timescale 1ns/1ps
`default_nettype none
module two_level_vectored_irq (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ext_input_zero,
   input  wire logic        ext_input_one,
   input  wire logic        timer_zero_irq,
   input  wire logic        timer_one_irq,
   input  wire logic        serial_bus_irq,
   input  wire logic        caption_mode,
   input  wire logic        caption_line_end,
   input  wire logic        hblank_entry,
   input  wire logic        vblank_entry,
   input  wire logic        busy_irq_mode_bit,
   input  wire logic [7:0]  irq_mask_register,
   input  wire logic [6:0]  priority_select_register,
   input  wire logic [1:0]  timer_control_register,
   input  wire logic        call_ack,
   input  wire logic        reti,
   output logic             long_call,
   output logic [15:0]      vector_addr,
   output logic [2:0]       granted_src,
   output logic [1:0]       in_service,
   output logic [6:0]       pending
);
   logic        pin0_lvl;
   logic        pin0_fall;
   logic        pin1_lvl;
   logic        pin1_fall;
   logic        pin1_rise;
   logic [6:0]  next_pending;
   logic [6:0]  raw_event;
   logic [6:0]  eligible;
   logic [6:0]  hi_req;
   logic [6:0]  lo_req;
   logic        pick_valid;
   logic [2:0]  pick_src;
   logic        pick_high;
   logic [1:0]  next_in_service;
   logic        next_long_call;
   logic [15:0] next_vector_addr;
   logic [2:0]  next_granted_src;
   logic        global_en;
   irq_pkg::dispatch_e state;
   irq_pkg::dispatch_e next_state;

   //////////////////////////////////////////////////////////////////////////////
   // Pin front ends
   irq_edge_sync sync_zero (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin     (ext_input_zero),
      .level   (pin0_lvl),
      .fall    (pin0_fall),
      .rise    ()
   );

   irq_edge_sync sync_one (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin     (ext_input_one),
      .level   (pin1_lvl),
      .fall    (pin1_fall),
      .rise    (pin1_rise)
   );

   // Vector for a source index, used by dispatch only
   function automatic logic [15:0] vector_of(input logic [2:0] src);
      vector_of = irq_pkg::VECTOR_BASE + irq_pkg::VECTOR_STEP * {13'h0000, src};
   endfunction

   // Lowest index set bit wins, matching the polling order
   function automatic logic [2:0] first_set(input logic [6:0] req);
      first_set = 3'h0;
      for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            first_set = 3'(i);
         end
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Request sources
   always_comb begin
      raw_event = 7'h00;
      raw_event[irq_pkg::SRC_PIN0] = timer_control_register[0] ? pin0_fall
                                                               : 1'b0;
      raw_event[irq_pkg::SRC_TMR0] = timer_zero_irq;
      raw_event[irq_pkg::SRC_PIN1] = timer_control_register[1]
                                     ? (pin1_fall | pin1_rise) : 1'b0;
      raw_event[irq_pkg::SRC_TMR1] = timer_one_irq;
      raw_event[irq_pkg::SRC_CAPT] = caption_mode & caption_line_end;
      raw_event[irq_pkg::SRC_SBUS] = serial_bus_irq;
      raw_event[irq_pkg::SRC_BLANK] = busy_irq_mode_bit ? vblank_entry
                                                        : hblank_entry;
   end

   // Pending flags: events set, the granted call clears; set wins
   always_comb begin
      next_pending = pending;
      if (state == irq_pkg::ST_CALL && call_ack) begin
         next_pending[granted_src] = 1'b0;
      end
      next_pending = next_pending | raw_event;
      // Level mode follows the pin directly, so it is not sticky
      next_pending[irq_pkg::SRC_PIN0] = timer_control_register[0]
         ? next_pending[irq_pkg::SRC_PIN0] : ~pin0_lvl;
      next_pending[irq_pkg::SRC_PIN1] = timer_control_register[1]
         ? next_pending[irq_pkg::SRC_PIN1] : ~pin1_lvl;
   end

   //////////////////////////////////////////////////////////////////////////////
   // Arbitration
   always_comb begin
      global_en = irq_mask_register[irq_pkg::GLOBAL_EN_BIT];
      eligible  = global_en ? (pending & irq_mask_register[6:0]) : 7'h00;
      hi_req    = eligible & priority_select_register;
      lo_req    = eligible & ~priority_select_register;
      pick_valid = 1'b0;
      pick_src   = 3'h0;
      pick_high  = 1'b0;
      if (hi_req != 7'h00 && !in_service[1]) begin
         pick_valid = 1'b1;
         pick_src   = first_set(hi_req);
         pick_high  = 1'b1;
      end else if (lo_req != 7'h00 && in_service == 2'h0) begin
         pick_valid = 1'b1;
         pick_src   = first_set(lo_req);
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Dispatch: hold the call request until the core acknowledges it
   always_comb begin
      next_state       = state;
      next_long_call   = long_call;
      next_vector_addr = vector_addr;
      next_granted_src = granted_src;
      next_in_service  = in_service;
      if (reti) begin
         // Release the highest level in service
         if (in_service[1]) begin
            next_in_service[1] = 1'b0;
         end else begin
            next_in_service[0] = 1'b0;
         end
      end
      case (state)
         irq_pkg::ST_IDLE: begin
            if (pick_valid && !reti) begin
               next_state       = irq_pkg::ST_CALL;
               next_long_call   = 1'b1;
               next_vector_addr = vector_of(pick_src);
               next_granted_src = pick_src;
               next_in_service[pick_high] = 1'b1;
            end
         end
         irq_pkg::ST_CALL: begin
            if (call_ack) begin
               next_state     = irq_pkg::ST_IDLE;
               next_long_call = 1'b0;
            end
         end
         default: begin
            next_state     = irq_pkg::ST_IDLE;
            next_long_call = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state       <= irq_pkg::ST_IDLE;
         long_call   <= 1'b0;
         vector_addr <= irq_pkg::VECTOR_RESET;
         granted_src <= 3'h0;
         in_service  <= irq_pkg::INSERVICE_RST;
         pending     <= 7'h00;
      end else begin
         state       <= next_state;
         long_call   <= next_long_call;
         vector_addr <= next_vector_addr;
         granted_src <= next_granted_src;
         in_service  <= next_in_service;
         pending     <= next_pending;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence call_start;
      !long_call ##1 long_call;
   endsequence

   // The index must be the pick of the decision cycle, not the old grant
   mask_block_a: assert property (@(posedge clk_sys) disable iff (rst)
      call_start |-> $past(irq_mask_register[pick_src]))
      else $error("call to a masked source");
   global_block_a: assert property (@(posedge clk_sys) disable iff (rst)
      call_start |-> $past(irq_mask_register[7]))
      else $error("call while globally disabled");
   vector_value_a: assert property (@(posedge clk_sys) disable iff (rst)
      long_call |-> vector_addr == 16'h0003 + {10'h000, granted_src, 3'h0})
      else $error("vector address wrong");
   high_noprempt_a: assert property (@(posedge clk_sys) disable iff (rst)
      in_service[1] && !reti && !long_call |=> !long_call)
      else $error("high level handler preempted");
   call_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      long_call && !call_ack |=> long_call && $stable(vector_addr))
      else $error("call dropped before acknowledge");
   high_first_a: assert property (@(posedge clk_sys) disable iff (rst)
      call_start ##0 $past(hi_req != 7'h00) |-> priority_select_register[granted_src]
         || $changed(priority_select_register))
      else $error("low granted over high");
   // No source of the granted level below the grant may have been eligible
   poll_order_a: assert property (@(posedge clk_sys) disable iff (rst)
      call_start |-> (($past(hi_req) != 7'h00 ? $past(hi_req) : $past(lo_req))
         & ((7'h01 << granted_src) - 7'h01)) == 7'h00)
      else $error("polling order violated");
   reti_release_a: assert property (@(posedge clk_sys) disable iff (rst)
      reti && in_service == 2'h1 |=> in_service == 2'h0 || long_call)
      else $error("return did not release level");
   caption_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      !caption_mode |-> !raw_event[irq_pkg::SRC_CAPT])
      else $error("caption request outside caption mode");
endmodule
`default_nettype wire

// *** pkg/irq_pkg.sv ***
// Constants for the two level vectored interrupt controller.
// Assumes a single core clock domain; no bus, all controls are ports.
`default_nettype none
package irq_pkg;
   localparam int          NUM_SRC        = 7;
   localparam int          SRC_W          = 3;
   // Source positions in polling order, highest first
   localparam logic [2:0]  SRC_PIN0       = 3'h0;
   localparam logic [2:0]  SRC_TMR0       = 3'h1;
   localparam logic [2:0]  SRC_PIN1       = 3'h2;
   localparam logic [2:0]  SRC_TMR1       = 3'h3;
   localparam logic [2:0]  SRC_CAPT       = 3'h4;
   localparam logic [2:0]  SRC_SBUS       = 3'h5;
   localparam logic [2:0]  SRC_BLANK      = 3'h6;
   // Mask register field positions
   localparam int          GLOBAL_EN_BIT  = 7;
   // Vector layout
   localparam logic [15:0] VECTOR_BASE    = 16'h0003;
   localparam logic [15:0] VECTOR_STEP    = 16'h0008;
   // Reset values
   localparam logic [7:0]  MASK_RESET     = 8'h00;
   localparam logic [6:0]  PRIO_RESET     = 7'h00;
   localparam logic [1:0]  TRIG_RESET     = 2'h0;
   localparam logic [1:0]  INSERVICE_RST  = 2'h0;
   localparam logic [15:0] VECTOR_RESET   = 16'h0000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CALL = 2'b10
   } dispatch_e;
endpackage
`default_nettype wire

// *** rtl/irq_edge_sync.sv ***
// Two flop synchroniser with edge detection for one external pin.
// Assumes an asynchronous pin input and one core clock.
`timescale 1ns/1ps
`default_nettype none
module irq_edge_sync (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic pin,
   output logic      level,
   output logic      fall,
   output logic      rise
);
   logic meta;
   logic sync;
   logic prev;
   logic next_meta;
   logic next_sync;
   logic next_prev;

   //////////////////////////////////////////////////////////////////////////////
   // Pins idle high so reset to 1 avoids a false falling edge
   always_comb begin
      next_meta = pin;
      next_sync = meta;
      next_prev = sync;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end

   assign level = sync;
   assign fall  = prev & ~sync;
   assign rise  = ~prev & sync;
endmodule
`default_nettype wire

// *** testbench/core_model.sv ***
// Core model: takes each long call and acknowledges it after a set delay.
// Assumes one clock shared with the controller and a sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       long_call,
   input  wire logic [3:0] ack_delay,
   output logic            call_ack
);
   logic [3:0] wait_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // One-cycle ack; skipped while the last ack is still seen, so no double take
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wait_cnt <= 4'h0;
         call_ack <= 1'b0;
      end else begin
         call_ack <= 1'b0;
         wait_cnt <= 4'h0;
         if (long_call && !call_ack) begin
            if (wait_cnt == ack_delay) begin
               call_ack <= 1'b1;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/two_level_vectored_irq_tb_top.sv ***
// Testbench for the vectored interrupt controller with a core model.
// Assumes pins idle high and all controls driven as plain ports.
`timescale 1ns/1ps
`default_nettype none
module two_level_vectored_irq_tb_top;
   logic        clk_sys, rst, ext_input_zero, ext_input_one, timer_zero_irq;
   logic        timer_one_irq, serial_bus_irq, caption_mode, caption_line_end;
   logic        hblank_entry, vblank_entry, busy_irq_mode_bit, call_ack, reti, long_call;
   logic [7:0]  irq_mask_register;
   logic [6:0]  priority_select_register, pending;
   logic [1:0]  timer_control_register, in_service;
   logic [15:0] vector_addr;
   logic [2:0]  granted_src;
   logic [3:0]  ack_delay;
   int          errors, samples_checked;

   two_level_vectored_irq i_dut (.clk_sys, .rst, .ext_input_zero, .ext_input_one,
      .timer_zero_irq, .timer_one_irq, .serial_bus_irq, .caption_mode, .caption_line_end,
      .hblank_entry, .vblank_entry, .busy_irq_mode_bit, .irq_mask_register,
      .priority_select_register, .timer_control_register, .call_ack, .reti, .long_call,
      .vector_addr, .granted_src, .in_service, .pending);
   core_model i_core (.clk_sys, .rst, .long_call, .ack_delay, .call_ack);

   // 40 MHz core clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task end_sim;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait; running out ends the run
   task wait_call(input logic lvl);
      int n;
      n = 0;
      #1;
      while (long_call !== lvl && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check(16'(long_call), 16'(lvl));
      if (long_call !== lvl) end_sim();
   endtask

   task expect_call(input int s);
      wait_call(1'b1);
      check(vector_addr, 16'h0003 + 16'h0008 * 16'(s));
      check(16'(granted_src), 16'(s));
      wait_call(1'b0);
   endtask

   task expect_none(input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(posedge clk_sys);
         #1;
         if (long_call !== 1'b0) bad++;
      end
      check(16'(bad), 16'h0000);
   endtask

   // Pins get a falling (pin0) or toggled (pin1) edge; the rest a 1-cycle pulse
   task fire(input logic [6:0] m);
      @(posedge clk_sys);
      {hblank_entry, serial_bus_irq, caption_line_end, timer_one_irq} <= m[6:3];
      timer_zero_irq <= m[1];
      if (m[0]) ext_input_zero <= 1'b0;
      if (m[2]) ext_input_one <= ~ext_input_one;
      @(posedge clk_sys);
      {hblank_entry, serial_bus_irq, caption_line_end, timer_one_irq, timer_zero_irq} <= 5'h00;
      ext_input_zero <= 1'b1;
   endtask

   task ret;
      @(posedge clk_sys);
      reti <= 1'b1;
      @(posedge clk_sys);
      reti <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task s_vectors;
      for (int s = 0; s < 7; s++) begin
         fire(7'h01 << s);
         expect_call(s);
         check(16'(in_service), 16'h0001);
         ret();
         check(16'(in_service), 16'h0000);
      end
      expect_none(12);
   endtask

   task s_order;
      @(posedge clk_sys);
      irq_mask_register <= 8'h7f;
      priority_select_register <= 7'h40;
      fire(7'h7f);
      expect_none(8);
      check(16'(pending), 16'h007f);
      @(posedge clk_sys);
      irq_mask_register <= 8'hff;
      expect_call(6);
      check(16'(in_service), 16'h0002);
      ret();
      for (int s = 0; s < 6; s++) begin
         expect_call(s);
         ret();
      end
   endtask

   task s_preempt;
      @(posedge clk_sys);
      priority_select_register <= 7'h02;
      ack_delay <= 4'h0;
      fire(7'h08);
      expect_call(3);
      fire(7'h20);
      expect_none(10);
      fire(7'h02);
      expect_call(1);
      check(16'(in_service), 16'h0003);
      fire(7'h08);
      expect_none(10);
      ret();
      expect_none(5);
      check(16'(in_service), 16'h0001);
      ret();
      expect_call(3);
      ret();
      expect_call(5);
      ret();
   endtask

   task s_masks;
      @(posedge clk_sys);
      ack_delay <= 4'h5;
      irq_mask_register <= 8'hfd;
      fire(7'h02);
      expect_none(10);
      @(posedge clk_sys);
      irq_mask_register <= 8'hff;
      expect_call(1);
      ret();
      @(posedge clk_sys);
      caption_mode <= 1'b0;
      fire(7'h10);
      expect_none(10);
      @(posedge clk_sys);
      caption_mode <= 1'b1;
      busy_irq_mode_bit <= 1'b1;
      fire(7'h40);
      expect_none(10);
      @(posedge clk_sys);
      vblank_entry <= 1'b1;
      @(posedge clk_sys);
      vblank_entry <= 1'b0;
      expect_call(6);
      ret();
      // Level mode keeps requesting while the pin is low
      @(posedge clk_sys);
      timer_control_register <= 2'h0;
      ext_input_zero <= 1'b0;
      expect_call(0);
      ret();
      expect_call(0);
      @(posedge clk_sys);
      ext_input_zero <= 1'b1;
      repeat (6) @(posedge clk_sys);
      ret();
      expect_none(10);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      {ext_input_zero, ext_input_one, caption_mode} = 3'h7;
      {timer_zero_irq, timer_one_irq, serial_bus_irq, caption_line_end} = 4'h0;
      {hblank_entry, vblank_entry, busy_irq_mode_bit, reti} = 4'h0;
      irq_mask_register = 8'hff;
      priority_select_register = 7'h00;
      timer_control_register = 2'h3;
      ack_delay = 4'h2;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      check(16'({long_call, in_service, pending}), 16'h0000);
      s_vectors();
      s_order();
      s_preempt();
      s_masks();
      end_sim();
   end
endmodule
`default_nettype wire
